// >>> hw/fifo_status_tx_length.sv
// FIFO occupancy status, transmit length and secondary test register.
// Assumes a host port decoded elsewhere into reg_addr/reg_wr/reg_rd strobes
// on mclk, and a host stop condition already synchronised to mclk.
//
// Behaviour
// - Setting decoder-test or an I/O-test bit enters test mode.
// - Test mode persists until next host stop condition or enable low.
// - Stop condition clears decoder-test and I/O-test bits.
// - Secondary test register resets to zero on power-on or enable low.
// - Bit 0 of test register runs coders from the carrier clock.
// - Status bit 6 set when receive FIFO holds 9 or more bytes.
// - Status bit 5 set during transmit when 3 or fewer bytes remain.
// - Status bit 4 flags overflow when host writes into a full FIFO.
// - Status bits 3..0 report unread byte count minus one.
// - Status bit 7 reserved, reads zero.
// - First length register holds count bits 11..4.
// - Both length registers reset on power-on, enable low, transmit end-of-frame.
// - Second length register holds low nibble, partial flag, partial bit count.
// - Second length register bits 7..4 carry count bits 3..0.
`timescale 1ns/1ps
`default_nettype none
`include "fifo_status_params.svh"
module fifo_status_tx_length #(
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int AW    = 4
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       chip_en,
  input  wire logic [4:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       host_stop,
  input  wire logic       host_fifo_wr,
  input  wire logic [7:0] host_fifo_wdata,
  input  wire logic       host_fifo_rd,
  output logic      [7:0] host_fifo_rdata,
  input  wire logic       coder_pop,
  output logic      [7:0] coder_data,
  output logic            coder_data_valid,
  input  wire logic       decoder_push,
  input  wire logic [7:0] decoder_data,
  input  wire logic       tx_active,
  input  wire logic       rx_active,
  input  wire logic       tx_eof,
  output logic            test_mode,
  output logic            coder_fast_clock,
  output logic            carrier_level_check,
  output logic      [11:0] tx_byte_count,
  output logic            tx_partial_valid,
  output logic      [2:0] tx_partial_bits
);
  // Count wide enough for DEPTH
  localparam int CW = AW + 1;

  logic [7:0]    test_reg, test_next;
  logic [7:0]    len_hi_reg, len_hi_next;
  logic [7:0]    len_lo_reg, len_lo_next;
  logic [CW-1:0] count_reg, count_next;
  logic [AW-1:0] wptr_reg, rptr_reg;
  logic          ovf_reg, ovf_next;
  logic          pop_d_reg;
  fifo_status_pkg::fifo_dir_t dir;

  // Address decode
  wire sel_test = (reg_addr == `OFS_SECONDARY_TEST_CONTROL);
  wire sel_stat = (reg_addr == `OFS_FIFO_OCCUPANCY_STATUS);
  wire sel_lhi  = (reg_addr == `OFS_TX_COUNT_UPPER);
  wire sel_llo  = (reg_addr == `OFS_TX_COUNT_LOWER_PARTIAL);

  // Power-on or enable low both hold the registers at reset value
  wire soft_clr = ~chip_en;

  // One store write per cycle: host or decoder push in any direction, not gated by dir
  wire full  = (count_reg == CW'(DEPTH));
  wire empty = (count_reg == '0);
  wire push_req = host_fifo_wr | decoder_push;
  wire push  = push_req & ~full;
  wire pop   = (host_fifo_rd | coder_pop) & ~empty;
  // Host data wins the store port when both sides push together
  wire [7:0] push_data = host_fifo_wr ? host_fifo_wdata : decoder_data;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign dir = tx_active ? fifo_status_pkg::DIR_TX :
               rx_active ? fifo_status_pkg::DIR_RX : fifo_status_pkg::DIR_IDLE;

  // Test register next value; stop wins over a same-cycle host write
  always_comb begin
    test_next = test_reg;
    if (reg_wr && sel_test) begin
      test_next = reg_wdata;
    end
    if (host_stop) begin
      test_next[`TEST_BIT_DECODER_TEST] = 1'b0;
      test_next[`TEST_BIT_IO_CHECK_LO]  = 1'b0;
      test_next[`TEST_BIT_IO_CHECK_HI]  = 1'b0;
    end
  end

  // Length registers; end-of-frame clear beats a host write in the same cycle
  always_comb begin
    len_hi_next = len_hi_reg;
    len_lo_next = len_lo_reg;
    if (reg_wr && sel_lhi) begin
      len_hi_next = reg_wdata;
    end
    if (reg_wr && sel_llo) begin
      len_lo_next = reg_wdata;
    end
    if (tx_eof) begin
      len_hi_next = `REG_RESET_VALUE;
      len_lo_next = `REG_RESET_VALUE;
    end
  end

  // Single occupancy counter; overflow sticks until enable drops
  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
    ovf_next = ovf_reg | (host_fifo_wr & full);
  end

  // Register state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      test_reg   <= `REG_RESET_VALUE;
      len_hi_reg <= `REG_RESET_VALUE;
      len_lo_reg <= `REG_RESET_VALUE;
    end else if (ce) begin
      if (soft_clr) begin
        test_reg   <= `REG_RESET_VALUE;
        len_hi_reg <= `REG_RESET_VALUE;
        len_lo_reg <= `REG_RESET_VALUE;
      end else begin
        test_reg   <= test_next;
        len_hi_reg <= len_hi_next;
        len_lo_reg <= len_lo_next;
      end
    end
  end

  // FIFO pointers, count and overflow
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      ovf_reg   <= 1'b0;
      pop_d_reg <= 1'b0;
    end else if (ce) begin
      if (soft_clr) begin
        count_reg <= '0;
        wptr_reg  <= '0;
        rptr_reg  <= '0;
        ovf_reg   <= 1'b0;
        pop_d_reg <= 1'b0;
      end else begin
        count_reg <= count_next;
        ovf_reg   <= ovf_next;
        pop_d_reg <= pop;
        if (push) begin
          wptr_reg <= wrap_inc(wptr_reg);
        end
        if (pop) begin
          rptr_reg <= wrap_inc(rptr_reg);
        end
      end
    end
  end

  logic [7:0] store_rd;
  byte_store #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_store (
    .mclk    (mclk),
    .ce      (ce),
    .wr_en   (push),
    .wr_addr (wptr_reg),
    .wr_data (push_data),
    .rd_addr (rptr_reg),
    .rd_data (store_rd)
  );

  // Status fields from the one counter
  wire lvl_high = (dir == fifo_status_pkg::DIR_RX) && (count_reg >= CW'(`LEVEL_HIGH_MARK));
  wire lvl_low  = (dir == fifo_status_pkg::DIR_TX) && (count_reg <= CW'(`LEVEL_LOW_MARK));
  wire [3:0] unread_m1 = empty ? 4'h0 : 4'(count_reg - 1'b1);
  wire [7:0] status = {1'b0, lvl_high, lvl_low, ovf_reg, unread_m1};

  // Read mux; unmapped offsets read zero
  wire [7:0] rd_mux = sel_test ? test_reg :
                      sel_stat ? status :
                      sel_lhi  ? len_hi_reg :
                      sel_llo  ? len_lo_reg : 8'h00;

  // Registered read data
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      host_fifo_rdata <= 8'h00;
      coder_data <= 8'h00;
      coder_data_valid <= 1'b0;
    end else if (ce) begin
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
      if (pop_d_reg) begin
        host_fifo_rdata <= store_rd;
        coder_data <= store_rd;
      end
      coder_data_valid <= pop_d_reg;
    end
  end

  // Test mode lasts exactly while a decoder-test or I/O-test bit is held
  assign test_mode = test_reg[`TEST_BIT_DECODER_TEST] | test_reg[`TEST_BIT_IO_CHECK_LO] |
                     test_reg[`TEST_BIT_IO_CHECK_HI];
  assign coder_fast_clock    = test_reg[`TEST_BIT_CODER_FAST_CLOCK];
  assign carrier_level_check = test_reg[`TEST_BIT_CARRIER_LEVEL];
  // Host is expected to load both bytes before starting
  assign tx_byte_count    = {len_hi_reg, len_lo_reg[7:4]};
  assign tx_partial_valid = len_lo_reg[0];
  assign tx_partial_bits  = len_lo_reg[3:1];
endmodule
`default_nettype wire

// >>> hw/fifo_status_params.svh
// Register offsets, field positions, reset values and sizes for the FIFO status block.
// Included by the package user files; definitions only.
`ifndef FIFO_STATUS_PARAMS_SVH
`define FIFO_STATUS_PARAMS_SVH

`define OFS_SECONDARY_TEST_CONTROL 5'h1b
`define OFS_FIFO_OCCUPANCY_STATUS  5'h1c
`define OFS_TX_COUNT_UPPER         5'h1d
`define OFS_TX_COUNT_LOWER_PARTIAL 5'h1e

`define TEST_BIT_CODER_FAST_CLOCK   0
`define TEST_BIT_DECODER_TEST       1
`define TEST_BIT_IO_CHECK_LO        2
`define TEST_BIT_IO_CHECK_HI        3
`define TEST_BIT_CARRIER_LEVEL      7

`define STAT_BIT_LEVEL_HIGH 6
`define STAT_BIT_LEVEL_LOW  5
`define STAT_BIT_OVERFLOW   4

`define REG_RESET_VALUE 8'h00
`define FIFO_DEPTH      12
`define LEVEL_HIGH_MARK 9
`define LEVEL_LOW_MARK  3

`endif

// >>> hw/fifo_status_pkg.sv
// Types shared by the FIFO status block.
// Assumes nothing of its surroundings.
`default_nettype none
package fifo_status_pkg;
  typedef enum logic [1:0] {
    DIR_IDLE,
    DIR_TX,
    DIR_RX
  } fifo_dir_t;
endpackage
`default_nettype wire

// >>> hw/byte_store.sv
// Small byte memory for the FIFO, read data registered.
// Assumes single-clock use with a clock enable.
`timescale 1ns/1ps
`default_nettype none
module byte_store #(
  parameter int DEPTH = 12,
  parameter int AW    = 4
) (
  input  wire logic          mclk,
  input  wire logic          ce,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);
  logic [7:0] mem [DEPTH];

  // Storage and registered read; contents need no reset
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// >>> dv/host_model.sv
// Host port driver: register strobes, stop condition and FIFO pushes/pops.
// Assumes the block samples every strobe on rising mclk.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  output logic      [4:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  output logic            host_stop,
  output logic            host_fifo_wr,
  output logic      [7:0] host_fifo_wdata,
  output logic            host_fifo_rd
);
  // Idle port at time zero
  initial begin
    {reg_addr, reg_wr, reg_rd, reg_wdata, host_stop} = '0;
    {host_fifo_wr, host_fifo_wdata, host_fifo_rd} = '0;
  end
  // Register write; data inverted after release so stale data never matches
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // Register read, data taken one cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    d = reg_rdata;
  endtask
  // Stop condition, one cycle
  task automatic stop();
    @(posedge mclk);
    host_stop <= 1'b1;
    @(posedge mclk);
    host_stop <= 1'b0;
  endtask
  // FIFO push and pop, one cycle each
  task automatic push(input logic [7:0] d);
    @(posedge mclk);
    host_fifo_wdata <= d;
    host_fifo_wr <= 1'b1;
    @(posedge mclk);
    host_fifo_wr <= 1'b0;
    host_fifo_wdata <= ~d;
  endtask
  task automatic pop();
    @(posedge mclk);
    host_fifo_rd <= 1'b1;
    @(posedge mclk);
    host_fifo_rd <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> dv/fifo_status_chk.sv
// Port-level assertions for the FIFO status and length block.
// Assumes one clock domain, mclk, with rst asynchronous and active high.
`timescale 1ns/1ps
`default_nettype none
module fifo_status_chk (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        chip_en,
  input wire logic [4:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        host_stop,
  input wire logic        tx_eof,
  input wire logic        test_mode,
  input wire logic        coder_fast_clock,
  input wire logic [11:0] tx_byte_count,
  input wire logic        tx_partial_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Accepted writes per register
  wire logic go = reg_wr && ce && chip_en;
  wire logic w1b = go && reg_addr == 5'h1b;
  wire logic w1d = go && reg_addr == 5'h1d;
  wire logic w1e = go && reg_addr == 5'h1e;
  a_test_entry: assert property (w1b && reg_wdata[3:1] != 3'h0 && !host_stop |=> test_mode)
    else $error("test mode not entered");
  a_test_hold: assert property (test_mode && chip_en && !host_stop && !w1b |=> test_mode)
    else $error("test mode dropped early");
  a_stop_clear: assert property (host_stop && ce |=> !test_mode)
    else $error("stop left test mode on");
  a_enable_low: assert property (ce && !chip_en |=> tx_byte_count == 12'h000 && !test_mode
    && !coder_fast_clock)
    else $error("enable low did not clear");
  a_fast_clock: assert property (w1b |=> coder_fast_clock == $past(reg_wdata[0]))
    else $error("fast clock bit wrong");
  a_eof_clear: assert property (ce && tx_eof |=> tx_byte_count == 12'h000 && !tx_partial_valid)
    else $error("length kept after eof");
  a_len_upper: assert property (w1d && !tx_eof |=> tx_byte_count[11:4] == $past(reg_wdata))
    else $error("upper count wrong");
  a_len_lower: assert property (w1e && !tx_eof |=> tx_byte_count[3:0] == $past(reg_wdata[7:4])
    && tx_partial_valid == $past(reg_wdata[0]))
    else $error("lower count wrong");
  a_rsvd_zero: assert property (ce && chip_en && reg_rd && reg_addr == 5'h1c |=> !reg_rdata[7])
    else $error("reserved status bit set");
endmodule
bind fifo_status_tx_length fifo_status_chk i_fifo_status_chk (.mclk, .rst, .ce, .chip_en, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata, .host_stop, .tx_eof, .test_mode, .coder_fast_clock, .tx_byte_count,
  .tx_partial_valid);
`default_nettype wire

// >>> dv/tb_fifo_status_tx_length.sv
// Self-checking bench: queue model of the FIFO and registers against the block.
// Assumes host_model drives the host port and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module tb_fifo_status_tx_length;
  logic        mclk = 1'b0, rst = 1'b1, ce = 1'b1, chip_en = 1'b1, coder_pop = 1'b0, decoder_push = 1'b0;
  logic        tx_active = 1'b0, rx_active = 1'b0, tx_eof = 1'b0, host_stop, reg_wr, reg_rd;
  logic        host_fifo_wr, host_fifo_rd, test_mode, coder_fast_clock, carrier_level_check;
  logic        tx_partial_valid, coder_data_valid, ovf = 1'b0;
  logic [7:0]  decoder_data = 8'h00, reg_wdata, reg_rdata, host_fifo_wdata, host_fifo_rdata, coder_data, rv, b, d2;
  logic [4:0]  reg_addr;
  logic [11:0] tx_byte_count;
  logic [2:0]  tx_partial_bits;
  logic [7:0]  q[$];
  int          err_count = 0, cmp_count = 0, seed = 32'h2d2b8ef2;
  fifo_status_tx_length i_fifo_status_tx_length (.mclk, .rst, .ce, .chip_en, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .host_stop, .host_fifo_wr, .host_fifo_wdata, .host_fifo_rd, .host_fifo_rdata,
    .coder_pop, .coder_data, .coder_data_valid, .decoder_push, .decoder_data, .tx_active, .rx_active, .tx_eof,
    .test_mode, .coder_fast_clock, .carrier_level_check, .tx_byte_count, .tx_partial_valid, .tx_partial_bits);
  host_model i_host_model (.mclk, .reg_rdata, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .host_stop,
    .host_fifo_wr, .host_fifo_wdata, .host_fifo_rd);
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  // Expected status byte from the model
  function automatic logic [7:0] st();
    st = {1'b0, rx_active && !tx_active && q.size() >= 9, tx_active && q.size() <= 3, ovf,
      q.size() > 0 ? 4'(q.size() - 1) : 4'h0};
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %0t: saw %h wanted %h", $time, s, e);
    end
  endtask
  task automatic rs(input logic [4:0] a, input logic [7:0] e);
    i_host_model.rd(a, rv);
    chk(16'(rv), 16'(e));
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 27; a < 31; a++) rs(5'(a), 8'h00);
    for (int k = 1; k < 4; k++) begin
      i_host_model.wr(5'h1b, 8'h81 | (8'h01 << k));
      repeat (4) @(posedge mclk);
      chk(16'({test_mode, coder_fast_clock, carrier_level_check}), 16'h0007);
      i_host_model.stop();
      @(posedge mclk);
      rs(5'h1b, 8'h81);
    end
    rx_active <= 1'b1;
    for (int k = 0; k < 13; k++) begin
      b = 8'($random(seed));
      if (k < 8 || k == 12) i_host_model.push(b);
      else begin
        @(posedge mclk);
        decoder_data <= b;
        decoder_push <= 1'b1;
        @(posedge mclk);
        decoder_push <= 1'b0;
      end
      if (q.size() < 12) q.push_back(b);
      else ovf = 1'b1;
      rs(5'h1c, st());
    end
    rx_active <= 1'b0;
    tx_active <= 1'b1;
    while (q.size() > 0) begin
      b = q.pop_front();
      if (q.size() % 2) i_host_model.pop();
      else begin
        @(posedge mclk);
        coder_pop <= 1'b1;
        @(posedge mclk);
        coder_pop <= 1'b0;
      end
      // Sample on the falling edge, clear of the edge that launches the pulse
      for (int n = 0; n < 4 && coder_data_valid !== 1'b1; n++) @(negedge mclk);
      chk(16'(coder_data_valid), 16'h0001);
      chk(16'(q.size() % 2 ? host_fifo_rdata : coder_data), 16'(b));
      rs(5'h1c, st());
    end
    chip_en <= 1'b0;
    @(posedge mclk);
    chip_en <= 1'b1;
    ovf = 1'b0;
    rs(5'h1c, st());
    repeat (3) begin
      b = 8'($random(seed));
      d2 = 8'($random(seed));
      i_host_model.wr(5'h1d, b);
      i_host_model.wr(5'h1e, d2);
      @(posedge mclk);
      chk({tx_byte_count, tx_partial_bits, tx_partial_valid}, {b, d2});
      rs(5'h1d, b);
      tx_eof <= 1'b1;
      @(posedge mclk);
      tx_eof <= 1'b0;
      rs(5'h1e, 8'h00);
      chk(16'(tx_byte_count), 16'h0000);
    end
    // Clock enable low freezes the length register against a write
    ce <= 1'b0;
    i_host_model.wr(5'h1d, 8'h5a);
    ce <= 1'b1;
    rs(5'h1d, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
